// ==== verilog/seed_key_wdog.sv ====
// Algorithmic seed/key watchdog with AXI4-Lite registers and reset-pin timer.
// Assumes aclk at 10 MHz; the disable pin and external reset request are async.
//
// Chosen here: the address map and register access over AXI4-Lite.
module seed_key_wdog
    import seed_key_wdog_pkg::*;
// Behaviour
// - Retry counter counts errors while qualifying
// - Qualified error after retries sets reset latch
// - Test indicator readable during test state
// - Lockout flag set at startup, drives pin
// - Recovery into run still possible after lockout
// - Test command enters test, override from init
// - Recover command clears retry counter
// - Error tally counts every service error
// - Service timer bounds time to correct key
// - Timer expiry without refresh raises service error
// - Correct keys accepted at any rate
// - Correct key latches seed, new key, restarts
// - Initial-seed state does the same sequence
// - Seed from counter running after release
// - Seed read returns seed and previous key
// - Key and seed are eight bits
// - Key is seed xor previous key plus one
// - Either watchdog reset pulses reset pin
// - Fault records survive watchdog reset pulse
// - Disable pin stops watchdog, timer, faults
// - Disable pin level shown in status word
// - Reset state lasts fixed time, exits itself
// - Test sets only reset latch, no lockout
// - State-machine reset returns init, clears reset latch, sets lockout
#(
    parameter int unsigned TIMEOUT_CYC  = DEF_TIMEOUT_CYC,
    parameter int unsigned RETRIES      = DEF_RETRIES,
    parameter int unsigned PIN_RST_CYC  = DEF_PIN_RST_CYC,
    parameter int unsigned STATE_CYC    = RESET_STATE_CYC
)
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // AXI4-Lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Pins
    input  wire logic        wdog_disable_pin,
    input  wire logic        window_wdog_rst,   // Reset request from window watchdog
    output logic             lockout_pin,
    output logic             reset_pin_n
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        wd_state_e   st;
        logic [31:0] service_timer;
        logic [31:0] state_timer;
        logic [31:0] pin_timer;
        logic [7:0]  retry_count;
        logic [7:0]  error_tally;
        logic [7:0]  seed_ctr;
        logic [7:0]  seed_div;
        logic [7:0]  seed;
        logic [7:0]  key_exp;
        logic [7:0]  key_prev;
        logic        wdog_reset_latch;
        logic        lockout_flag;
        logic [1:0]  dis_sync;
        logic [1:0]  wrst_sync;
        logic        wrst_old;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } wd_s;

    wd_s s_q;
    wd_s s_d;

    // ****************************************************************
    // Combinational next state
    // ****************************************************************
    logic       dis_lvl;
    logic       wr_fire;
    logic       key_cmd;
    logic       test_cmd;
    logic       recov_cmd;
    logic       sm_rst;
    logic       key_ok;
    logic       expired;
    logic [7:0] new_key;

    // Synchronised pin, write decode, key check
    always_comb
    begin
        dis_lvl   = s_q.dis_sync[1];
        wr_fire   = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        key_cmd   = wr_fire && s_q.aw_addr == OFS_KEY && s_q.w_strb[0];
        test_cmd  = wr_fire && s_q.aw_addr == OFS_CMD && s_q.w_data[CMD_TEST];
        recov_cmd = wr_fire && s_q.aw_addr == OFS_CMD && s_q.w_data[CMD_RECOVER];
        sm_rst    = wr_fire && s_q.aw_addr == OFS_CTRL && s_q.w_data[CTRL_SMRST];
        key_ok    = key_cmd && s_q.w_data[KEY_W-1:0] == s_q.key_exp;
        // Expiry is checked before a key in the same cycle can refresh
        // Held off while disabled so the first disabled cycle cannot raise a fault
        expired   = !dis_lvl && s_q.service_timer >= TIMEOUT_CYC - 1;
        new_key   = (s_q.seed_ctr ^ s_q.key_exp) + KEY_INC;
    end

    // Main next-state process
    always_comb
    begin
        s_d = s_q;

        // Synchronisers: first stage read only by the second
        s_d.dis_sync  = {s_q.dis_sync[0], wdog_disable_pin};
        s_d.wrst_sync = {s_q.wrst_sync[0], window_wdog_rst};
        s_d.wrst_old  = s_q.wrst_sync[1];

        // Free-running seed counter, prescaled
        s_d.seed_div = s_q.seed_div + 8'h01;
        if (s_q.seed_div == 8'(SEED_DIV - 1))
        begin
            s_d.seed_div = '0;
            s_d.seed_ctr = s_q.seed_ctr + 8'h01;
        end

        // Timers run every cycle; cleared where the machine restarts them
        if (s_q.service_timer < TIMEOUT_CYC)
            s_d.service_timer = s_q.service_timer + 32'h1;
        if (s_q.state_timer < STATE_CYC)
            s_d.state_timer = s_q.state_timer + 32'h1;
        if (s_q.pin_timer != '0)
            s_d.pin_timer = s_q.pin_timer - 32'h1;

        // Window-watchdog reset pulses the pin too
        if (s_q.wrst_sync[1] && !s_q.wrst_old)
            s_d.pin_timer = PIN_RST_CYC;

        if (recov_cmd)
            s_d.retry_count = '0;

        // Watchdog state machine
        unique case (s_q.st)
            S_INIT:
            begin
                s_d.service_timer = '0;
                if (test_cmd)
                    s_d.st = S_OVERRIDE;
                else if (key_ok)
                begin
                    s_d.seed    = s_q.seed_ctr;
                    s_d.key_prev = s_q.key_exp;
                    s_d.key_exp = new_key;
                    s_d.st      = S_INITIAL_SEED_STATE;
                end
            end
            S_OVERRIDE:
                s_d.service_timer = '0;
            S_INITIAL_SEED_STATE, S_RUN, S_QUAL:
            begin
                if (test_cmd)
                begin
                    s_d.st          = S_TEST;
                    s_d.state_timer = '0;
                end
                else if (expired)
                begin
                    // Service error
                    s_d.error_tally   = s_q.error_tally + 8'h01;
                    s_d.service_timer = '0;
                    if (s_q.st != S_QUAL)
                        s_d.st = S_QUAL;
                    else if (s_q.retry_count < 8'(RETRIES))
                        s_d.retry_count = s_q.retry_count + 8'h01;
                    else
                    begin
                        s_d.wdog_reset_latch = 1'b1;
                        s_d.lockout_flag     = 1'b1;
                        s_d.pin_timer        = PIN_RST_CYC;
                        s_d.state_timer      = '0;
                        s_d.st               = S_RESET;
                    end
                end
                else if (key_ok)
                begin
                    // Any rate of correct keys just keeps restarting the timer
                    s_d.seed          = s_q.seed_ctr;
                    s_d.key_prev      = s_q.key_exp;
                    s_d.key_exp       = new_key;
                    s_d.service_timer = '0;
                    s_d.st            = S_RUN;
                end
            end
            S_TEST:
            begin
                // Only the reset latch moves; no pin pulse, lockout untouched
                s_d.wdog_reset_latch = 1'b1;
                s_d.service_timer    = '0;
                if (s_q.state_timer >= STATE_CYC - 1)
                    s_d.st = S_INITIAL_SEED_STATE;
            end
            S_RESET:
            begin
                s_d.service_timer = '0;
                if (s_q.state_timer >= STATE_CYC - 1)
                    s_d.st = S_INITIAL_SEED_STATE;
            end
            default:
                s_d.st = S_INIT;
        endcase

        // Disable pin holds everything idle and fault free
        if (dis_lvl)
        begin
            s_d.service_timer = '0;
            if (s_q.st != S_INIT && s_q.st != S_OVERRIDE)
                s_d.st = S_INIT;
            s_d.wdog_reset_latch = s_q.wdog_reset_latch;
            s_d.error_tally      = s_q.error_tally;
            s_d.retry_count      = s_q.st == S_QUAL ? s_q.retry_count : s_d.retry_count;
        end

        // State-machine reset: back to init, reset latch and retries cleared, lockout set
        if (sm_rst)
        begin
            s_d.st               = S_INIT;
            s_d.service_timer    = '0;
            s_d.retry_count      = '0;
            // A latch set in this very cycle wins over the clear
            s_d.wdog_reset_latch = s_d.wdog_reset_latch && !s_q.wdog_reset_latch;
            s_d.lockout_flag     = 1'b1;   // Lockout is its startup level
            s_d.key_exp          = KEY_RESET;
            s_d.key_prev         = KEY_RESET;
        end

        // ************************************************************
        // AXI4-Lite write channel
        // ************************************************************
        if (awvalid && awready)
        begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = {awaddr[7:2], 2'b00};
        end
        if (wvalid && wready)
        begin
            s_d.w_got  = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end
        if (wr_fire)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = (s_q.aw_addr == OFS_KEY || s_q.aw_addr == OFS_CMD ||
                          s_q.aw_addr == OFS_CTRL) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_q.bvalid && bready)
            s_d.bvalid = 1'b0;

        // ************************************************************
        // AXI4-Lite read channel
        // ************************************************************
        if (arvalid && arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            s_d.rdata  = '0;
            unique case ({araddr[7:2], 2'b00})
                OFS_STATUS:
                begin
                    s_d.rdata[ST_WDR]     = s_q.wdog_reset_latch;
                    s_d.rdata[ST_TEST]    = s_q.st == S_TEST;
                    s_d.rdata[ST_LOCKOUT] = s_q.lockout_flag;
                    s_d.rdata[ST_DISPIN]  = dis_lvl;
                    s_d.rdata[ST_STATE_LO +: 4] = s_q.st;
                    s_d.rdata[ST_RETRY_LO +: 8] = s_q.retry_count;
                    s_d.rdata[ST_ERR_LO +: 8]   = s_q.error_tally;
                    s_d.rdata[ST_TMR_LO +: 8]   = s_q.service_timer[19:12];
                end
                OFS_SEED:
                    s_d.rdata[15:0] = {s_q.key_prev, s_q.seed};
                default:
                    s_d.rresp = RESP_SLVERR;
            endcase
        end
        if (s_q.rvalid && rready)
            s_d.rvalid = 1'b0;

        // Synchronous reset to defined values
        if (!aresetn)
        begin
            s_d              = '0;
            s_d.st           = S_INIT;
            s_d.lockout_flag = 1'b1;
            s_d.key_exp      = KEY_RESET;
            s_d.key_prev     = KEY_RESET;
        end
    end

    // Register the whole state
    always_ff @(posedge aclk)
    begin
        s_q <= s_d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // One write and one read in flight; ready while the slot is empty
    assign awready     = !s_q.aw_got && !s_q.bvalid;
    assign wready      = !s_q.w_got && !s_q.bvalid;
    assign bvalid      = s_q.bvalid;
    assign bresp       = s_q.bresp;
    assign arready     = !s_q.rvalid;
    assign rvalid      = s_q.rvalid;
    assign rdata       = s_q.rdata;
    assign rresp       = s_q.rresp;
    assign lockout_pin = s_q.lockout_flag;
    assign reset_pin_n = (s_q.pin_timer == '0);

endmodule

// ==== verilog/seed_key_wdog_pkg.sv ====
// Constants, register map and state encoding for the seed/key watchdog.
// Assumes a 10 MHz aclk and an AXI4-Lite master with 32-bit data.
package seed_key_wdog_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned RESET_STATE_US  = 1000;     // Timed reset state, 1 ms
    localparam int unsigned RESET_STATE_CYC = (RESET_STATE_US * (CLK_HZ / 1_000_000));
    localparam int unsigned DEF_TIMEOUT_CYC = 100_000;  // Service timeout, 10 ms
    localparam int unsigned DEF_RETRIES     = 3;
    localparam int unsigned DEF_PIN_RST_CYC = 2_000;    // Reset pin pulse, 200 us
    localparam int unsigned SEED_DIV        = 4;        // Seed counter prescale

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_STATUS  = 8'h00;  // Global status word, read only
    localparam logic [7:0] OFS_KEY     = 8'h04;  // Write: key command
    localparam logic [7:0] OFS_SEED    = 8'h08;  // Read: seed command
    localparam logic [7:0] OFS_CMD     = 8'h0C;  // Write: test / recover commands
    localparam logic [7:0] OFS_CTRL    = 8'h10;  // Write: state-machine reset

    // Status field positions
    localparam int unsigned ST_WDR      = 0;
    localparam int unsigned ST_TEST     = 1;
    localparam int unsigned ST_LOCKOUT  = 2;
    localparam int unsigned ST_DISPIN   = 3;
    localparam int unsigned ST_STATE_LO = 4;
    localparam int unsigned ST_RETRY_LO = 8;
    localparam int unsigned ST_ERR_LO   = 16;
    localparam int unsigned ST_TMR_LO   = 24;

    // Command bits in OFS_CMD and OFS_CTRL
    localparam int unsigned CMD_TEST    = 0;
    localparam int unsigned CMD_RECOVER = 1;
    localparam int unsigned CTRL_SMRST  = 0;

    // Key and seed
    localparam int unsigned KEY_W       = 8;
    localparam logic [7:0]  KEY_RESET   = 8'h00;    // Default key expected in init
    localparam logic [7:0]  KEY_INC     = 8'h01;

    // AXI responses
    localparam logic [1:0] RESP_OKAY    = 2'b00;
    localparam logic [1:0] RESP_SLVERR  = 2'b10;

    typedef enum logic [3:0] {
        S_INIT,
        S_OVERRIDE,
        S_INITIAL_SEED_STATE,
        S_RUN,
        S_TEST,
        S_QUAL,
        S_RESET
    } wd_state_e;

endpackage

// ==== sim/seed_key_wdog_chk.sv ====
// Port checker for the seed/key watchdog.
// Assumes it is bound into seed_key_wdog and sees only its ports.
module seed_key_wdog_chk
#(
    parameter int unsigned PIN_RST_CYC = 10
)
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        rready,
    // Pins
    input wire logic        lockout_pin,
    input wire logic        reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] low_cnt_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ********
    // Reset pin pulse length, counted so no long repetition is unrolled
    // ********
    always_ff @(posedge aclk)
    begin
        if (!aresetn || reset_pin_n)
            low_cnt_q <= 16'h0000;
        else
            low_cnt_q <= low_cnt_q + 16'h0001;
    end
    chk_pulse_len: assert property ($rose(reset_pin_n) |-> low_cnt_q == 16'(PIN_RST_CYC))
        else $error("reset pin pulse has wrong length");
    chk_pulse_max: assert property (!reset_pin_n |-> low_cnt_q < 16'(PIN_RST_CYC))
        else $error("reset pin held low too long");
    // Startup levels and lockout latch
    chk_lock_start: assert property ($rose(aresetn) |-> lockout_pin && reset_pin_n)
        else $error("pins wrong after reset release");
    chk_lock_sticky: assert property (lockout_pin |=> lockout_pin)
        else $error("lockout flag dropped");
    // Bus answers; commands act only through these
    chk_ar_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data not answered next cycle");
    chk_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    chk_ar_block: assert property (rvalid |-> !arready)
        else $error("read address taken while data pending");
    chk_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response missing");
    chk_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response not held");
    chk_w_block: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
endmodule

bind seed_key_wdog seed_key_wdog_chk #(.PIN_RST_CYC(PIN_RST_CYC)) chk_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
    .rready(rready), .lockout_pin(lockout_pin), .reset_pin_n(reset_pin_n));

// ==== sim/host_key_model.sv ====
// Host-side key calculator for the watchdog bench.
// Assumes the host has just read the seed word over the bus.
module host_key_model
(
    // Seed word as read back
    input  wire logic [7:0] seed,
    input  wire logic [7:0] prev_key,
    // Key the host sends next
    output logic      [7:0] next_key
);
    timeunit 1ns;
    timeprecision 1ns;
    // Wraps at eight bits, as the device does
    assign next_key = (seed ^ prev_key) + 8'h01;
endmodule

// ==== sim/algorithmic_seed_key_watchdog_test.sv ====
// Self-checking bench for the seed/key watchdog.
// Assumes short parameter values so timeouts fit a short run.
module algorithmic_seed_key_watchdog_test
    import seed_key_wdog_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, dis_pin, win_rst;
    logic        lockout_pin, reset_pin_n;
    logic [7:0]  awaddr, araddr, seed_v, prev_v, key_v, last_key;
    logic [31:0] wdata, rdata, s;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    int          miscompares, tests_run, pin_falls, falls0;
    seed_key_wdog #(.TIMEOUT_CYC(50), .RETRIES(3), .PIN_RST_CYC(10), .STATE_CYC(20)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .wdog_disable_pin(dis_pin),
        .window_wdog_rst(win_rst), .lockout_pin(lockout_pin), .reset_pin_n(reset_pin_n));
    host_key_model host_u (.seed(seed_v), .prev_key(prev_v), .next_key(key_v));
    // ********
    // Clock, pin monitor and watchdog
    // ********
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(negedge reset_pin_n) pin_falls++;
    initial
    begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        end_of_test();
    end
    // ********
    // Bus tasks; samples at the falling edge so the rising edge sees settled values
    // ********
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic hit_aw, hit_w, hit_b;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(negedge aclk);
            hit_aw = awvalid && awready;
            hit_w  = wvalid && wready;
            hit_b  = bvalid;
            rs     = bresp;
            @(posedge aclk);
            if (hit_aw)
                awvalid <= 1'b0;
            if (hit_w)
                wvalid <= 1'b0;
        end while (!hit_b);
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic hit_ar, hit_r;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(negedge aclk);
            hit_ar = arvalid && arready;
            hit_r  = rvalid;
            d      = rdata;
            rs     = rresp;
            @(posedge aclk);
            if (hit_ar)
                arvalid <= 1'b0;
        end while (!hit_r);
        rready <= 1'b0;
    endtask
    // Polls the status word; bounded so a stuck state shows as a mismatch
    task automatic wait_state(input logic [3:0] st);
        int n;
        n = 0;
        do
        begin
            axi_read(OFS_STATUS, s, r);
            n++;
        end while (s[7:4] !== st && n < 300);
        check_word("state", 32'(st), 32'(s[7:4]));
    endtask
    // Host reads seed and previous key, then answers with the next key
    task automatic host_key(input logic chk_prev);
        logic [31:0] d;
        axi_read(OFS_SEED, d, r);
        if (chk_prev)
            check_word("prev key", 32'(last_key), 32'(d[15:8]));
        seed_v = d[7:0];
        prev_v = d[15:8];
        #1;
        axi_write(OFS_KEY, 32'(key_v), r);
        last_key = key_v;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ********
    // Test sequence
    // ********
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, dis_pin, win_rst} = 8'h00;
        {awaddr, araddr, seed_v, prev_v, last_key} = 40'h00_0000_0000;
        {wdata, wstrb} = 36'h0_0000_000F;
        miscompares = 0;
        tests_run = 0;
        pin_falls = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(OFS_STATUS, s, r);
        check_word("status", 32'h0000_0004, s & 32'h00FF_FFFF);
        axi_read(8'h20, s, r);
        check_word("unmapped rd", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, r});
        check_word("lockout pin", 32'h0000_0001, 32'(lockout_pin));
        axi_write(8'h20, 32'h0000_0001, r);
        check_word("unmapped wr", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, r});
        $display("reset values done");
        axi_write(OFS_CMD, 32'h0000_0001, r);
        check_word("cmd resp", {30'h0000_0000, RESP_OKAY}, {30'h0000_0000, r});
        wait_state(S_OVERRIDE);
        axi_write(OFS_CTRL, 32'h0000_0001, r);
        wait_state(S_INIT);
        $display("override done");
        axi_write(OFS_KEY, 32'(KEY_RESET), r);
        wait_state(S_INITIAL_SEED_STATE);
        for (int i = 0; i < 4; i++)
            host_key(i > 0);
        wait_state(S_RUN);
        check_word("err tally", 32'h0000_0000, 32'(s[23:16]));
        $display("key service done");
        axi_write(OFS_KEY, 32'(key_v ^ 8'h5A), r);
        falls0 = pin_falls;
        wait_state(S_QUAL);
        check_word("err tally", 32'h0000_0001, 32'(s[23:16]));
        wait_state(S_RESET);
        check_word("latch+lock", 32'h0000_0005, s & 32'h0000_0007);
        check_word("retries", 32'h0000_0003, 32'(s[15:8]));
        wait_state(S_INITIAL_SEED_STATE);
        check_word("latch kept", 32'h0000_0001, 32'(s[0]));
        check_word("pin pulses", 32'(falls0 + 1), 32'(pin_falls));
        axi_write(OFS_CMD, 32'h0000_0002, r);
        axi_read(OFS_STATUS, s, r);
        check_word("retry clr", 32'h0000_0000, 32'(s[15:8]));
        host_key(1'b0);
        wait_state(S_RUN);
        $display("qualify and recover done");
        falls0 = pin_falls;
        axi_write(OFS_CMD, 32'h0000_0001, r);
        wait_state(S_TEST);
        check_word("test ind", 32'h0000_0001, 32'(s[1]));
        wait_state(S_INITIAL_SEED_STATE);
        check_word("no pulse", 32'(falls0), 32'(pin_falls));
        $display("test mode done");
        dis_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        wait_state(S_INIT);
        check_word("dis bit", 32'h0000_0001, 32'(s[3]));
        dis_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        axi_read(OFS_STATUS, s, r);
        check_word("dis bit", 32'h0000_0000, 32'(s[3]));
        win_rst <= 1'b1;
        repeat (3) @(posedge aclk);
        win_rst <= 1'b0;
        repeat (20) @(posedge aclk);
        check_word("win pulse", 32'(falls0 + 1), 32'(pin_falls));
        $display("pins done");
        end_of_test();
    end
endmodule
